// ---- ams_pkg.sv ----
package ams_pkg;

    // ------------------------------------------------------------
    // register map (word byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SEL1 = 8'h00;
    localparam logic [7:0] ADDR_SEL2 = 8'h04;
    localparam logic [7:0] ADDR_OFS1 = 8'h08;
    localparam logic [7:0] ADDR_OFS2 = 8'h0C;
    localparam logic [7:0] ADDR_MAG1 = 8'h10;
    localparam logic [7:0] ADDR_MAG2 = 8'h14;
    localparam logic [7:0] ADDR_CFG = 8'h18;
    localparam logic [7:0] ADDR_DAC1 = 8'h1C;
    localparam logic [7:0] ADDR_DAC2 = 8'h20;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] SEL1_RST = 16'h0002;
    localparam logic [15:0] SEL2_RST = 16'h0000;
    localparam logic [15:0] OFS_RST = 16'h0000;
    localparam logic [15:0] MAG_RST = 16'h0064;
    localparam int CFG_LINEAR_BIT = 0;

    // ------------------------------------------------------------
    // selection codes (low byte of selection register)
    // ------------------------------------------------------------
    localparam logic [7:0] SEL_SPEED = 8'h00;
    localparam logic [7:0] SEL_SPD_REF = 8'h01;
    localparam logic [7:0] SEL_TRQ_REF = 8'h02;
    localparam logic [7:0] SEL_POS_DEV = 8'h03;
    localparam logic [7:0] SEL_AMP_DEV = 8'h04;
    localparam logic [7:0] SEL_POS_SPD = 8'h05;
    localparam logic [7:0] SEL_RESERVED = 8'h06;
    localparam logic [7:0] SEL_LOAD_DEV = 8'h07;
    localparam logic [7:0] SEL_POS_DONE = 8'h08;
    localparam logic [7:0] SEL_SPD_FF = 8'h09;
    localparam logic [7:0] SEL_TRQ_FF = 8'h0A;
    localparam logic [7:0] SEL_GAIN = 8'h0B;
    localparam logic [7:0] SEL_DIST_DONE = 8'h0C;
    localparam logic [7:0] SEL_EXT_SPD = 8'h0D;
    localparam logic [7:0] SEL_DC_BUS = 8'h10;

    // ------------------------------------------------------------
    // voltage representation: signed millivolts internally
    // source units: speed 1 min-1 or 1 mm/s, torque 0.01 %,
    // deviations 1 unit, bus 1 V
    // ------------------------------------------------------------
    localparam logic [15:0] SETTING_MAX = 16'h2710;
    localparam int MV_PER_OFS_STEP = 100;
    localparam int MAG_DIV = 100;
    localparam int MV_PER_DEV = 50;
    localparam int MV_PER_LOAD_DEV = 10;
    localparam int MV_FLAG_ON = 5000;
    localparam int MV_GAIN1 = 1000;
    localparam int MV_GAIN2 = 2000;
    localparam int TRQ_DIV = 10;
    localparam int BUS_DIV = 100;
    localparam int DAC_FULL_MV = 8000;
    localparam logic signed [15:0] DAC_MAX = 16'sh7FFF;
    localparam logic signed [15:0] DAC_MIN = -16'sh7FFF;

endpackage

// ---- ams_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
// one channel: scale, magnify, offset, negate, saturate to 16-bit code
module ams_channel (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] sel,
    input wire logic linear_mode,
    input wire logic signed [15:0] mag,
    input wire logic signed [15:0] ofs,
    input wire logic signed [31:0] spd,
    input wire logic signed [31:0] spd_ref,
    input wire logic signed [31:0] pos_spd,
    input wire logic signed [31:0] spd_ff,
    input wire logic signed [31:0] ext_spd,
    input wire logic signed [31:0] trq_ref,
    input wire logic signed [31:0] trq_ff,
    input wire logic signed [31:0] pos_dev,
    input wire logic signed [31:0] amp_dev,
    input wire logic signed [31:0] load_dev,
    input wire logic pos_done,
    input wire logic dist_done,
    input wire logic gain2_active,
    input wire logic signed [31:0] dc_bus,
    output logic signed [15:0] dac_code
);
    logic signed [47:0] src_mv;
    logic signed [63:0] out_mv;
    logic signed [63:0] code_w;
    logic signed [15:0] dac_q;
    logic signed [15:0] dac_d;

    // ------------------------------------------------------------
    // source scaling to millivolts
    // ------------------------------------------------------------
    always_comb begin
        case (sel)
            // speed: 1 mV per rpm or per mm/s, same figure both ways
            ams_pkg::SEL_SPEED: src_mv = 48'(spd);
            ams_pkg::SEL_SPD_REF: src_mv = 48'(spd_ref);
            ams_pkg::SEL_POS_SPD: src_mv = 48'(pos_spd);
            ams_pkg::SEL_SPD_FF: src_mv = 48'(spd_ff);
            ams_pkg::SEL_TRQ_REF: src_mv = 48'(trq_ref) / ams_pkg::TRQ_DIV;
            ams_pkg::SEL_TRQ_FF: src_mv = 48'(trq_ff) / ams_pkg::TRQ_DIV;
            ams_pkg::SEL_POS_DEV: src_mv = 48'(pos_dev) * ams_pkg::MV_PER_DEV;
            ams_pkg::SEL_AMP_DEV: src_mv = 48'(amp_dev) * ams_pkg::MV_PER_DEV;
            ams_pkg::SEL_LOAD_DEV: src_mv = 48'(load_dev) * ams_pkg::MV_PER_LOAD_DEV;
            ams_pkg::SEL_POS_DONE: src_mv = pos_done ? 48'(ams_pkg::MV_FLAG_ON) : 48'sh0;
            ams_pkg::SEL_GAIN: src_mv = gain2_active ? 48'(ams_pkg::MV_GAIN2)
                                                     : 48'(ams_pkg::MV_GAIN1);
            ams_pkg::SEL_DIST_DONE: src_mv = dist_done ? 48'(ams_pkg::MV_FLAG_ON)
                                                       : 48'sh0;
            ams_pkg::SEL_EXT_SPD: src_mv = linear_mode ? 48'sh0 : 48'(ext_spd);
            ams_pkg::SEL_DC_BUS: src_mv = 48'(dc_bus) * 1000 / ams_pkg::BUS_DIV;
            default: src_mv = 48'sh0;
        endcase
    end

    // ------------------------------------------------------------
    // magnify, offset, negate, map 8 V to full scale, clamp
    // ------------------------------------------------------------
    always_comb begin
        out_mv = -((64'(src_mv) * 64'(mag)) / ams_pkg::MAG_DIV
                   + 64'(ofs) * ams_pkg::MV_PER_OFS_STEP);
        code_w = (out_mv * 64'(ams_pkg::DAC_MAX)) / ams_pkg::DAC_FULL_MV;
        // clamp in millivolts first, so a large product cannot wrap the code
        if (out_mv > 64'(ams_pkg::DAC_FULL_MV)) begin
            dac_d = ams_pkg::DAC_MAX;
        end else if (out_mv < -64'(ams_pkg::DAC_FULL_MV)) begin
            dac_d = ams_pkg::DAC_MIN;
        end else begin
            dac_d = code_w[15:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dac_q <= 16'sh0;
        end else begin
            dac_q <= dac_d;
        end
    end

    assign dac_code = dac_q;

    a_code_bounded: assert property (@(posedge mclk) disable iff (!rst_n)
        dac_code >= ams_pkg::DAC_MIN) else $error("dac code below floor");
    a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel == ams_pkg::SEL_RESERVED && ofs == 16'sh0) |=> dac_code == 16'sh0)
        else $error("reserved code not silent");

endmodule
`default_nettype wire

// ---- ams_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - two channels, each selects its source by the low byte of its select register
// - codes 00,01,05,09 give speed quantities at 1 V per 1000 rpm
// - linear motors scale speed quantities at 1 V per 1000 mm/s
// - codes 02 and 0A give torque at 1 V per 100 % rated
// - code 03 gives position deviation at 0.05 V per unit
// - code 04 gives amplifier deviation at 0.05 V per encoder pulse
// - code 07 gives motor-load deviation at 0.01 V per unit
// - code 08 gives 5 V when positioning complete, else 0 V
// - code 0B gives 1 V for first gain set, 2 V for second
// - code 0C gives 5 V when distribution complete, else 0 V
// - code 0D gives external encoder speed at 1 V per 1000 rpm, 0 V in linear mode
// - code 10 gives DC bus at 1 V per 100 V
// - output is minus (scaled signal times magnification plus offset)
// - offset is -10000..10000 in 0.1 V, reset 0, immediate
// - magnification is -10000..10000 in 0.01, reset 100, immediate
// - converter is 16 bits spanning plus or minus 8 V
module ams_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic signed [31:0] spd,
    input wire logic signed [31:0] spd_ref,
    input wire logic signed [31:0] pos_spd,
    input wire logic signed [31:0] spd_ff,
    input wire logic signed [31:0] ext_spd,
    input wire logic signed [31:0] trq_ref,
    input wire logic signed [31:0] trq_ff,
    input wire logic signed [31:0] pos_dev,
    input wire logic signed [31:0] amp_dev,
    input wire logic signed [31:0] load_dev,
    input wire logic pos_done,
    input wire logic dist_done,
    input wire logic gain2_active,
    input wire logic signed [31:0] dc_bus,
    output logic [15:0] dac1_code,
    output logic [15:0] dac2_code
);
    logic [15:0] sel_q [2];
    logic [15:0] ofs_q [2];
    logic [15:0] mag_q [2];
    logic linear_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [15:0] wr_val;
    logic wr_en;
    logic in_range;
    logic signed [15:0] code [2];

    // ------------------------------------------------------------
    // wishbone slave: one wait state, ack one cycle
    // ------------------------------------------------------------
    // a write lands at the edge where the master sees ack
    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    assign wr_val = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                     wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};
    // out-of-range settings are dropped, the old value stays
    assign in_range = ($signed(wr_val) <= $signed(ams_pkg::SETTING_MAX))
                      && ($signed(wr_val) >= -$signed(ams_pkg::SETTING_MAX));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    assign wb_ack_o = ack_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sel_q[0] <= ams_pkg::SEL1_RST;
            sel_q[1] <= ams_pkg::SEL2_RST;
            ofs_q[0] <= ams_pkg::OFS_RST;
            ofs_q[1] <= ams_pkg::OFS_RST;
            mag_q[0] <= ams_pkg::MAG_RST;
            mag_q[1] <= ams_pkg::MAG_RST;
            linear_q <= 1'b0;
        end else if (wr_en) begin
            case (wb_adr_i)
                ams_pkg::ADDR_SEL1: sel_q[0] <= wr_val;
                ams_pkg::ADDR_SEL2: sel_q[1] <= wr_val;
                ams_pkg::ADDR_OFS1: if (in_range) ofs_q[0] <= wr_val;
                ams_pkg::ADDR_OFS2: if (in_range) ofs_q[1] <= wr_val;
                ams_pkg::ADDR_MAG1: if (in_range) mag_q[0] <= wr_val;
                ams_pkg::ADDR_MAG2: if (in_range) mag_q[1] <= wr_val;
                ams_pkg::ADDR_CFG: linear_q <= wr_val[ams_pkg::CFG_LINEAR_BIT];
                default: ;
            endcase
        end
    end

    always_comb begin
        case (wb_adr_i)
            ams_pkg::ADDR_SEL1: rdat_d = {16'h0000, sel_q[0]};
            ams_pkg::ADDR_SEL2: rdat_d = {16'h0000, sel_q[1]};
            ams_pkg::ADDR_OFS1: rdat_d = {16'h0000, ofs_q[0]};
            ams_pkg::ADDR_OFS2: rdat_d = {16'h0000, ofs_q[1]};
            ams_pkg::ADDR_MAG1: rdat_d = {16'h0000, mag_q[0]};
            ams_pkg::ADDR_MAG2: rdat_d = {16'h0000, mag_q[1]};
            ams_pkg::ADDR_CFG: rdat_d = {31'h00000000, linear_q};
            ams_pkg::ADDR_DAC1: rdat_d = {16'h0000, code[0]};
            ams_pkg::ADDR_DAC2: rdat_d = {16'h0000, code[1]};
            default: rdat_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_q <= 32'h00000000;
        end else begin
            rdat_q <= rdat_d;
        end
    end

    assign wb_dat_o = ack_q ? rdat_q : 32'h00000000;

    // ------------------------------------------------------------
    // two monitor channels
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        ams_channel u_ch (
            .mclk(mclk),
            .rst_n(rst_n),
            .sel(sel_q[ch][7:0]),
            .linear_mode(linear_q),
            .mag(mag_q[ch]),
            .ofs(ofs_q[ch]),
            .spd(spd),
            .spd_ref(spd_ref),
            .pos_spd(pos_spd),
            .spd_ff(spd_ff),
            .ext_spd(ext_spd),
            .trq_ref(trq_ref),
            .trq_ff(trq_ff),
            .pos_dev(pos_dev),
            .amp_dev(amp_dev),
            .load_dev(load_dev),
            .pos_done(pos_done),
            .dist_done(dist_done),
            .gain2_active(gain2_active),
            .dc_bus(dc_bus),
            .dac_code(code[ch])
        );
    end

    assign dac1_code = code[0];
    assign dac2_code = code[1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_ack_single: assert property (@(posedge mclk) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_timely: assert property (@(posedge mclk) disable iff (!rst_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack missing");
    a_mag_range: assert property (@(posedge mclk) disable iff (!rst_n)
        $signed(mag_q[0]) <= $signed(ams_pkg::SETTING_MAX)
        && $signed(mag_q[0]) >= -$signed(ams_pkg::SETTING_MAX)) else $error("mag out of range");
    a_ofs_range: assert property (@(posedge mclk) disable iff (!rst_n)
        $signed(ofs_q[0]) >= -$signed(ams_pkg::SETTING_MAX)
        && $signed(ofs_q[0]) <= $signed(ams_pkg::SETTING_MAX)) else $error("ofs out of range");
    a_flag_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel_q[0][7:0] == ams_pkg::SEL_POS_DONE && !pos_done && ofs_q[0] == 16'h0000)
        |=> dac1_code == 16'h0000) else $error("flag off not zero");
    a_gain_neg: assert property (@(posedge mclk) disable iff (!rst_n)
        (sel_q[0][7:0] == ams_pkg::SEL_GAIN && $signed(mag_q[0]) > 0
         && ofs_q[0] == 16'h0000) |=> $signed(dac1_code) < 0)
        else $error("gain level not negated");
    a_write_now: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_en && wb_adr_i == ams_pkg::ADDR_OFS2 && in_range) |=> ofs_q[1] == $past(wr_val))
        else $error("offset write lost");
    a_code_limit: assert property (@(posedge mclk) disable iff (!rst_n)
        $signed(dac2_code) <= ams_pkg::DAC_MAX) else $error("code above ceiling");
    c_write: cover property (@(posedge mclk) wr_en && wb_adr_i == ams_pkg::ADDR_MAG1);
    c_sat: cover property (@(posedge mclk) $signed(dac1_code) == ams_pkg::DAC_MAX);
    c_bus: cover property (@(posedge mclk) sel_q[1][7:0] == ams_pkg::SEL_DC_BUS);

endmodule
`default_nettype wire

// ---- ams_recorder.sv ----
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// measuring instrument at both monitor outputs
// ------------------------------------------------------------
module ams_recorder (
    input wire logic mclk,
    input wire logic [15:0] code1,
    input wire logic [15:0] code2,
    output var int mv1,
    output var int mv2
);
    // samples each converter code as millivolts, full code is 8 V
    always_ff @(posedge mclk) begin
        mv1 <= int'($signed(code1)) * 8000 / 32767;
        mv2 <= int'($signed(code2)) * 8000 / 32767;
    end
endmodule
`default_nettype wire

// ---- ams_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ams_top_tb;
    logic mclk;
    logic rst_n;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack;
    logic signed [31:0] src [12];
    logic [2:0] flg;
    logic [15:0] dac1;
    logic [15:0] dac2;
    int mv1;
    int mv2;
    int n_mismatch;
    int check_count;
    // ------------------------------------------------------------
    // source table: only the selected source is non-zero per entry
    // ------------------------------------------------------------
    logic [7:0] t_code [16] = '{8'h00, 8'h01, 8'h05, 8'h09, 8'h0D, 8'h02, 8'h0A, 8'h03,
                                8'h04, 8'h07, 8'h10, 8'h08, 8'h08, 8'h0C, 8'h0B, 8'h0B};
    int t_src [16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 11, 11, 11, 11};
    int t_val [16] = '{8000, 8000, 8000, 8000, 8000, 80000, 80000, 160, 160, 800, 800,
                       0, 0, 0, 0, 0};
    logic [2:0] t_flg [16] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0, 2, 4, 0};
    int t_mag [16] = '{100, 100, 100, 100, 100, 100, 100, 100, 100, 100, 100,
                       160, 160, 160, 400, 800};
    logic [15:0] t_exp [16] = '{16'h8001, 16'h8001, 16'h8001, 16'h8001, 16'h8001,
                                16'h8001, 16'h8001, 16'h8001, 16'h8001, 16'h8001,
                                16'h8001, 16'h8001, 16'h0000, 16'h8001, 16'h8001, 16'h8001};
    logic [7:0] t_adr [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
    logic [15:0] t_rst [8] = '{16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0064,
                               16'h0000, 16'h0000};

    ams_top i_dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .spd(src[0]), .spd_ref(src[1]), .pos_spd(src[2]), .spd_ff(src[3]), .ext_spd(src[4]),
        .trq_ref(src[5]), .trq_ff(src[6]), .pos_dev(src[7]), .amp_dev(src[8]),
        .load_dev(src[9]), .pos_done(flg[0]), .dist_done(flg[1]), .gain2_active(flg[2]),
        .dc_bus(src[10]), .dac1_code(dac1), .dac2_code(dac2));

    ams_recorder i_rec (.mclk(mclk), .code1(dac1), .code2(dac2), .mv1(mv1), .mv2(mv2));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // one classic bus cycle, held until ack is sampled high
    // ------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            close_out();
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, {16'h0000, d});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(rd, {16'h0000, e});
    endtask

    // program channel 1, drive one source and compare its converter code
    task automatic run1(input logic [7:0] c, input logic [15:0] m, input logic [15:0] o,
                        input int k, input int v, input logic [2:0] f, input logic [15:0] e);
        @(posedge mclk);
        foreach (src[j]) src[j] <= (j == k) ? 32'(v) : 32'sh0;
        flg <= f;
        wr(ams_pkg::ADDR_SEL1, {8'h00, c});
        wr(ams_pkg::ADDR_MAG1, m);
        wr(ams_pkg::ADDR_OFS1, o);
        repeat (3) @(posedge mclk);
        chk({16'h0000, dac1}, {16'h0000, e});
    endtask

    initial begin
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0000_0000;
        flg = 3'h0;
        n_mismatch = 0;
        check_count = 0;
        foreach (src[j]) src[j] = 32'sh0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        chk({dac1, dac2}, 32'h0000_0000);
        wr(8'h40, 16'h1234);
        for (int i = 0; i < 8; i++) rd_chk(t_adr[i], t_rst[i]);
        // the reserved code is never selected here
        for (int i = 0; i < 16; i++) begin
            run1(t_code[i], 16'(t_mag[i]), 16'h0000, t_src[i], t_val[i], t_flg[i],
                 t_exp[i]);
        end
        chk(32'(mv1), 32'hFFFF_E0C0);
        run1(8'h00, 16'h0064, 16'h0050, 0, 0, 3'h0, 16'h8001);
        run1(8'h00, 16'h0064, 16'hFFB0, 0, 0, 3'h0, 16'h7FFF);
        run1(8'h00, 16'h0064, 16'h0028, 0, 4000, 3'h0, 16'h8001);
        run1(8'h00, 16'hFF9C, 16'h0000, 0, 8000, 3'h0, 16'h7FFF);
        run1(8'h00, 16'h0064, 16'h2710, 0, 0, 3'h0, 16'h8001);
        run1(8'h00, 16'h2710, 16'hD8F0, 0, 100, 3'h0, 16'h7FFF);
        wr(ams_pkg::ADDR_OFS1, 16'h2711);
        rd_chk(ams_pkg::ADDR_OFS1, 16'hD8F0);
        wr(ams_pkg::ADDR_MAG1, 16'hD8EF);
        rd_chk(ams_pkg::ADDR_MAG1, 16'h2710);
        run1(8'h00, 16'h0064, 16'h0000, 5, 40000, 3'h0, 16'h0000);
        wr(ams_pkg::ADDR_SEL2, 16'h0002);
        wr(ams_pkg::ADDR_MAG2, 16'h00C8);
        repeat (3) @(posedge mclk);
        chk({16'h0000, dac2}, 32'h0000_8001);
        wr(ams_pkg::ADDR_DAC2, 16'h0000);
        rd_chk(ams_pkg::ADDR_DAC2, 16'h8001);
        wr(ams_pkg::ADDR_CFG, 16'h0001);
        run1(8'h01, 16'h0064, 16'h0000, 1, 8000, 3'h0, 16'h8001);
        // undefined code: offset only, the selected speed must not pass
        run1(8'h0E, 16'h0064, 16'h0028, 0, 8000, 3'h0, 16'hC001);
        wr(ams_pkg::ADDR_OFS2, 16'h0014);
        rd_chk(ams_pkg::ADDR_OFS2, 16'h0014);
        sel <= 4'h1;
        wr(ams_pkg::ADDR_SEL2, 16'hAB10);
        sel <= 4'hF;
        rd_chk(ams_pkg::ADDR_SEL2, 16'h0010);
        close_out();
    end
endmodule
`default_nettype wire
